// ==== rtl/bnac_pkg.sv ====
// Purpose: shared constants for the byte nonvolatile access controller
// Assumes: 8-bit I/O register space of the core, 100 MHz system clock
// Notes: offsets are I/O register addresses
package bnac_pkg;
	localparam logic [5:0] BNAC_CTRL_ADDR = 6'h1c;
	localparam logic [5:0] BNAC_DATA_ADDR = 6'h1d;
	localparam logic [5:0] BNAC_ADDR_ADDR = 6'h1e;
	localparam logic [7:0] BNAC_CTRL_RESET = 8'h00;
	localparam logic [7:0] BNAC_DATA_RESET = 8'h00;
	localparam logic [5:0] BNAC_ADDR_RESET = 6'h00;
	localparam int BNAC_READ_BIT = 0;
	localparam int BNAC_WRITE_BIT = 1;
	localparam int BNAC_ADDR_W = 6;
	localparam int BNAC_DEPTH = 64;
	localparam int BNAC_CLK_MHZ = 100;
	// self-timed programming time, microseconds
	localparam int BNAC_WRITE_TIME_US = 2500;
	localparam int BNAC_WRITE_CYCLES = BNAC_WRITE_TIME_US * BNAC_CLK_MHZ;
	localparam int BNAC_WRITE_STALL = 2;
	localparam int BNAC_READ_STALL = 4;
	typedef enum logic [1:0] {BNAC_IDLE, BNAC_PROG} bnac_state_t;
endpackage : bnac_pkg

// ==== rtl/bnac_stall.sv ====
// Purpose: holds the core stalled for a loaded number of cycles
// Assumes: load is a one-cycle pulse
// Notes: stall output is registered
`timescale 1ns/1ps
`default_nettype none
module bnac_stall (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic load,
	input wire logic [2:0] cycles,
	output logic stall
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic stall_q;
	logic stall_d;

	// count down while nonzero; stall follows the next count
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = cycles;
		end else if (cnt_q != 3'h0) begin
			cnt_d = cnt_q - 3'h1;
		end
		stall_d = (cnt_d != 3'h0);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q <= 3'h0;
			stall_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			stall_q <= stall_d;
		end
	end

	assign stall = stall_q; // straight from a flop
endmodule : bnac_stall
`default_nettype wire

// ==== rtl/bnac_top.sv ====
// Purpose: control of byte reads and writes of a 64-byte data memory
// Assumes: core gives one-cycle io_wr / io_rd strobes with a 6-bit address
// Notes: programming time is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// (RQ1) control bits 7..2 read as zero and hold nothing
// (RQ2) address and data loaded first, then write strobe programs the byte
// (RQ3) hardware clears write strobe after the self-timed programming time
// (RQ4) software polls write strobe low before the next write
// (RQ5) core stalls two cycles after write strobe is set
// (RQ6) address loaded first, then read strobe requests the read
// (RQ7) read strobe clears itself once the byte sits in the data register
// (RQ8) core stalls four cycles after read strobe is set
// (RQ9) software must not touch address or data during an access
// (RQ10) both strobes reset to zero
// (RQ11) address register is 6 bits, upper two read as zero
// (RQ12) data register supplies write byte and receives read byte
// (RQ13) write strobe ignored while a write is still programming
module bnac_top
	import bnac_pkg::*;
#(
	parameter int WRITE_CYCLES = BNAC_WRITE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic cpu_stall
);
	bnac_state_t state_q;
	bnac_state_t state_d;
	logic we_q;
	logic we_d;
	logic re_q;
	logic re_d;
	logic [5:0] addr_q;
	logic [5:0] addr_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [21:0] tmr_q;
	logic [21:0] tmr_d;
	logic [5:0] paddr_q;
	logic [5:0] paddr_d;
	logic [7:0] pdata_q;
	logic [7:0] pdata_d;
	logic hit_addr;
	logic hit_data;
	logic hit_ctrl;
	logic rd_go;
	logic wr_go;
	logic stall_load;
	logic [2:0] stall_cycles;
	logic stall_w;
	logic mem_we;
	logic [7:0] mem [0:BNAC_DEPTH-1];

	// register file read view
	function automatic logic [7:0] rd_mux(input logic [5:0] a,
		input logic w, input logic r, input logic [5:0] ad,
		input logic [7:0] dt);
		rd_mux = 8'h00;
		unique case (a)
			BNAC_CTRL_ADDR: rd_mux = {6'h00, w, r}; // [RQ1]
			BNAC_DATA_ADDR: rd_mux = dt;
			BNAC_ADDR_ADDR: rd_mux = {2'b00, ad}; // [RQ11]
			default: rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// true when the core writes the register at offset sel
	function automatic logic reg_hit(input logic [5:0] a, input logic wr,
		input logic [5:0] sel);
		reg_hit = wr && (a == sel);
	endfunction : reg_hit

	//////////////////////////////////////////////////////////////////////////
	// access decode of the core's register writes
	always_comb begin
		hit_addr = reg_hit(io_addr, io_wr, BNAC_ADDR_ADDR);
		hit_data = reg_hit(io_addr, io_wr, BNAC_DATA_ADDR);
		hit_ctrl = reg_hit(io_addr, io_wr, BNAC_CTRL_ADDR);
		// a read strobe wins over a write strobe in the same byte
		rd_go = hit_ctrl && io_wdata[BNAC_READ_BIT]; // [RQ6]
		wr_go = hit_ctrl && !io_wdata[BNAC_READ_BIT]
			&& io_wdata[BNAC_WRITE_BIT]
			&& !we_q; // [RQ13]
	end

	//////////////////////////////////////////////////////////////////////////
	// write sequencer: latch the byte, time the programming, clear strobe
	always_comb begin
		state_d = state_q;
		we_d = we_q;
		tmr_d = tmr_q;
		paddr_d = paddr_q;
		pdata_d = pdata_q;
		mem_we = 1'b0;
		unique case (state_q)
			BNAC_IDLE: begin
				if (wr_go) begin
					we_d = 1'b1; // [RQ2]
					// latched so later register writes cannot disturb it
					paddr_d = addr_q;
					pdata_d = data_q; // [RQ12]
					tmr_d = 22'(WRITE_CYCLES - 1);
					state_d = BNAC_PROG;
				end
			end
			BNAC_PROG: begin
				// write strobes are refused here, the byte in flight stays
				if (tmr_q == 22'h0) begin
					mem_we = 1'b1; // [RQ2]
					we_d = 1'b0; // [RQ3]
					state_d = BNAC_IDLE;
				end else begin
					tmr_d = tmr_q - 22'h1;
				end
			end
			// illegal code: back to idle with the strobe dropped
			default: begin
				state_d = BNAC_IDLE;
				we_d = 1'b0;
			end
		endcase
	end

	// write sequencer registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= BNAC_IDLE;
			we_q <= BNAC_CTRL_RESET[BNAC_WRITE_BIT]; // [RQ10]
			tmr_q <= 22'h0;
			paddr_q <= 6'h00;
			pdata_q <= 8'h00;
		end else if (clk_en) begin
			state_q <= state_d;
			we_q <= we_d;
			tmr_q <= tmr_d;
			paddr_q <= paddr_d;
			pdata_q <= pdata_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// address, data and read-back registers
	always_comb begin
		addr_d = addr_q;
		data_d = data_q;
		// the read strobe clears itself in the cycle it is set
		re_d = 1'b0; // [RQ7]
		if (hit_addr) begin
			addr_d = io_wdata[5:0]; // [RQ11]
		end
		if (hit_data) begin
			data_d = io_wdata; // [RQ12]
		end
		// byte fetched at once, so software never polls for it
		if (rd_go) begin
			data_d = mem[addr_q]; // [RQ6] [RQ12]
		end
		// read-back shows the register as it stands after this edge
		rdata_d = rd_mux(io_addr, we_d, re_d, addr_d, data_d); // [RQ1]
	end

	// register file registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			re_q <= BNAC_CTRL_RESET[BNAC_READ_BIT]; // [RQ10]
			addr_q <= BNAC_ADDR_RESET;
			data_q <= BNAC_DATA_RESET;
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			re_q <= re_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// core stall after an accepted strobe; a dropped one does not stall
	always_comb begin
		stall_load = rd_go || wr_go;
		stall_cycles = 3'h0;
		if (rd_go) begin
			stall_cycles = 3'(BNAC_READ_STALL); // [RQ8]
		end else if (wr_go) begin
			stall_cycles = 3'(BNAC_WRITE_STALL); // [RQ5]
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// memory array, programmed at the end of the timed write
	always_ff @(posedge clk_sys) begin
		if (clk_en && mem_we) begin
			mem[paddr_q] <= pdata_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// stall of the core after a strobe
	bnac_stall u_stall (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.load(stall_load),
		.cycles(stall_cycles),
		.stall(stall_w)
	);

	assign io_rdata = rdata_q;
	assign cpu_stall = stall_w;
endmodule : bnac_top
`default_nettype wire

// ==== testbench/bnac_monitor.sv ====
// Purpose: port checks of the access controller
// Assumes: clk_en stays high while a stall is running
// Notes: bound into bnac_top below
`timescale 1ns/1ps
`default_nettype none
module bnac_monitor #(parameter int WRITE_CYCLES = 8) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic cpu_stall
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// control register select and strobe writes
	wire logic ctl = clk_en && io_addr == 6'h1c;
	wire logic s_r = ctl && io_wr && io_wdata[0];
	wire logic s_w = ctl && io_wr && io_wdata[1:0] == 2'h2;
	a_rsv_zero: assert property (ctl |=> io_rdata[7:2] == 6'h00)
		else $error("rsv bits");
	a_rd_clear: assert property (ctl |=> !io_rdata[0])
		else $error("read bit");
	a_addr_rsv: assert property (clk_en && io_addr == 6'h1e
		|=> io_rdata[7:6] == 2'h0) else $error("addr bits");
	a_rd_stall: assert property (s_r
		|=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall");
	a_wr_stall: assert property (s_w ##1 cpu_stall
		|=> cpu_stall ##1 !cpu_stall) else $error("write stall");
	a_wr_flag: assert property (s_w ##1 cpu_stall
		|-> io_rdata == 8'h02) else $error("write flag");
	a_stall_cause: assert property ($rose(cpu_stall)
		|-> $past(s_r || s_w)) else $error("stray stall");
	a_rst_idle: assert property (disable iff (1'b0) reset
		|=> io_rdata == 8'h00 && !cpu_stall) else $error("reset");
endmodule : bnac_monitor
bind bnac_top bnac_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
	.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .cpu_stall(cpu_stall));
`default_nettype wire

// ==== testbench/bnac_core_model.sv ====
// Purpose: core issuing I/O register accesses
// Assumes: access taken at the edge after the strobe
// Notes: halts while the stall is high
`timescale 1ns/1ps
`default_nettype none
module bnac_core_model (
	input wire logic clk_sys,
	input wire logic [7:0] io_rdata,
	input wire logic cpu_stall,
	output logic clk_en,
	output logic [5:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	initial clk_en = 1'b1;
	initial {io_addr, io_wr, io_rd, io_wdata} = 16'h0000;
	// address and data held until taken, then wait out the stall
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clk_sys);
		#1 io_wr = 1'b0;
		while (cpu_stall) @(posedge clk_sys) #1;
	endtask : wr
	// register value shows the cycle after the address
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1 io_addr = a;
		@(posedge clk_sys);
		#1 d = io_rdata;
	endtask : rd
	// hold the clock enable low for n cycles; all state must stand still
	task automatic freeze(input int n);
		@(posedge clk_sys);
		#1 clk_en = 1'b0;
		repeat (n) @(posedge clk_sys);
		#1 clk_en = 1'b1;
	endtask : freeze
endmodule : bnac_core_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench of the access controller
// Assumes: programming time shortened to 16 cycles
// Notes: accesses go through the core model
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic clk_en, io_wr, io_rd, cpu_stall;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, io_rdata, v, e;
	int num_errors = 0;
	int checks_done = 0;
	int k;
	always #5 clk_sys = ~clk_sys;
	bnac_top #(.WRITE_CYCLES(16)) u_dut (.clk_sys, .reset, .clk_en,
		.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .cpu_stall);
	bnac_core_model u_core (.clk_sys, .io_rdata, .cpu_stall, .clk_en,
		.io_addr, .io_wr, .io_rd, .io_wdata);
	// compare one register value
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_core.rd(a, d);
		chk(d, exp);
	endtask : rc
	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	// watchdog
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	// tests
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 reset = 1'b0;
		rc(6'h1c, 8'h00);
		u_core.wr(6'h1c, 8'hfc);
		rc(6'h1c, 8'h00);
		u_core.wr(6'h1e, 8'hff);
		rc(6'h1e, 8'h3f);
		for (int i = 0; i < 2; i++) begin
			e = i ? 8'ha5 : 8'h5a;
			u_core.wr(6'h1e, i ? 8'h3f : 8'h00);
			u_core.wr(6'h1d, e);
			u_core.wr(6'h1c, 8'h02);
			rc(6'h1c, 8'h02);
			u_core.wr(6'h1d, ~e);
			u_core.wr(6'h1c, 8'h02);
			k = 0;
			do begin
				u_core.rd(6'h1c, v);
				k++;
			end while (v[1] && k < 20);
			chk(v, 8'h00);
			u_core.wr(6'h1c, 8'h01);
			rc(6'h1d, e);
			rc(6'h1c, 8'h00);
		end
		// a low clock enable holds the programming timer
		u_core.wr(6'h1e, 8'h05);
		u_core.wr(6'h1d, 8'hc3);
		u_core.wr(6'h1c, 8'h02);
		u_core.freeze(40);
		rc(6'h1c, 8'h02);
		k = 0;
		do begin
			u_core.rd(6'h1c, v);
			k++;
		end while (v[1] && k < 20);
		chk(v, 8'h00);
		u_core.wr(6'h1c, 8'h01);
		rc(6'h1d, 8'hc3);
		summarize();
	end
endmodule : tb
`default_nettype wire
